/* File: fptr_flash_dev.sv */
// Flash device end: parameter table readout plus the mode state
// that the table describes.
// Assumes the host pulses req for one cycle and waits for ack.
`timescale 1ns/1ps
module fptr_flash_dev
  import fptr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  fptr_link_if.dev lnk,
  output logic addr4_mode,
  output logic cont_mode,
  output logic quad_mode,
  output logic quad_enable,
  output logic [7:0] ext_addr
);
  // Answer path
  logic ack_ff;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  // Write enable latches
  logic wel_ff;
  logic vwe_ff;
  logic nxt_wel;
  logic nxt_vwe;
  // Status register 1 copies
  logic [7:0] nv_sr1_ff;
  logic [7:0] v_sr1_ff;
  logic vact_ff;
  logic [7:0] nxt_nv_sr1;
  logic [7:0] nxt_v_sr1;
  logic nxt_vact;
  // Reset enable arming
  logic rst_en_ff;
  logic nxt_rst_en;
  // Addressing state
  logic addr4_ff;
  logic [7:0] ext_ff;
  logic nxt_addr4;
  logic [7:0] nxt_ext;
  // Read modes
  logic cont_ff;
  logic qpi_ff;
  logic qe_out_ff;
  logic nxt_cont;
  logic nxt_qpi;
  // Decoded commands, each qualified by req
  wire go = lnk.req;
  wire c_table = go && (lnk.op == OP_RD_TABLE);
  wire c_wren = go && (lnk.op == OP_WREN);
  wire c_vwren = go && (lnk.op == OP_VWREN);
  wire c_wrsr1 = go && (lnk.op == OP_WRSR1);
  wire c_rdsr1 = go && (lnk.op == OP_RDSR1);
  wire c_rst_en = go && (lnk.op == OP_RST_EN);
  wire c_rst = go && (lnk.op == OP_RST);
  wire c_en4b = go && (lnk.op == OP_EN4B);
  wire c_ex4b = go && (lnk.op == OP_EX4B);
  wire c_wr_ext = go && (lnk.op == OP_WR_EXT);
  wire c_rd_ext = go && (lnk.op == OP_RD_EXT);
  wire c_qread = go && (lnk.op == OP_QREAD);
  wire c_mrst = go && (lnk.op == OP_MODE_RST);
  wire c_qpi_qe = go && (lnk.op == OP_QPI_QE);
  wire c_qpi_dir = go && (lnk.op == OP_QPI_DIR);
  wire c_state = go && (lnk.op == OP_RD_STATE);
  // Soft reset fires only right after an armed reset enable
  wire soft_rst = c_rst && rst_en_ff;
  // Active status register: volatile copy wins once activated
  wire [7:0] sr1_eff = vact_ff ? v_sr1_ff : nv_sr1_ff;
  wire qe = sr1_eff[QE_POS];
  // Exit clock count depends on the address width in use
  wire [7:0] exit_need = addr4_ff ? EXIT_CLK_4B : EXIT_CLK_3B;
  // Mode byte with upper nibble Axh keeps continuous mode on
  wire mode_keep = (lnk.arg[7:4] == MODE_NIB);
  // Table lookup; a constant, so no command can alter it
  logic [7:0] table_byte;
  fptr_table_rom u_rom
  (
    .addr (lnk.arg),
    .data (table_byte)
  );
  // Mode flags packed for the state read
  wire [7:0] state_byte = {qpi_ff, cont_ff, addr4_ff, vact_ff,
                           vwe_ff, wel_ff, rst_en_ff, qe};
  // Answer byte selection; others answer zero
  assign nxt_rdata = c_table ? table_byte :
                     c_rdsr1 ? sr1_eff :
                     c_rd_ext ? ext_ff :
                     c_state ? state_byte : BYTE_ZERO;
  // Enables clear after a status write or a soft reset
  assign nxt_wel = c_wren ? 1'b1 :
                   (c_wrsr1 || soft_rst) ? 1'b0 : wel_ff;
  assign nxt_vwe = c_vwren ? 1'b1 :
                   (c_wrsr1 || soft_rst) ? 1'b0 : vwe_ff;
  // Volatile write takes priority over the non-volatile one
  assign nxt_v_sr1 = (c_wrsr1 && vwe_ff) ? lnk.arg :
                     soft_rst ? SR1_RST : v_sr1_ff;
  assign nxt_vact = (c_wrsr1 && vwe_ff) ? 1'b1 :
                    soft_rst ? 1'b0 : vact_ff;
  // Non-volatile copy survives soft reset
  assign nxt_nv_sr1 = (c_wrsr1 && !vwe_ff && wel_ff) ? lnk.arg :
                      nv_sr1_ff;
  // Any command other than reset enable disarms the reset
  assign nxt_rst_en = go ? c_rst_en : rst_en_ff;
  // 4-byte entry and exit need no write enable
  assign nxt_addr4 = c_en4b ? 1'b1 :
                     (c_ex4b || soft_rst) ? 1'b0 :
                     addr4_ff;
  // Extended address register, lowest segment after reset
  assign nxt_ext = c_wr_ext ? lnk.arg :
                   soft_rst ? EXT_RST : ext_ff;
  // Continuous mode: only entered while quad enable is set
  assign nxt_cont = c_qread ? (qe && mode_keep) :
                    (c_mrst && (lnk.arg >= exit_need)) ? 1'b0 :
                    soft_rst ? 1'b0 : cont_ff;
  // Quad entry: 38h needs the enable bit, 35h does not
  assign nxt_qpi = (c_qpi_qe && qe) ? 1'b1 :
                   c_qpi_dir ? 1'b1 :
                   soft_rst ? 1'b0 : qpi_ff;
  // Answer one cycle after each request
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ack_ff <= 1'b0;
      rdata_ff <= BYTE_ZERO;
    end
    else
    begin
      ack_ff <= go;
      rdata_ff <= nxt_rdata;
    end
  end
  // Write enables and reset arming
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wel_ff <= 1'b0;
      vwe_ff <= 1'b0;
      rst_en_ff <= 1'b0;
    end
    else
    begin
      wel_ff <= nxt_wel;
      vwe_ff <= nxt_vwe;
      rst_en_ff <= nxt_rst_en;
    end
  end
  // Status register copies; power-up uses the stored value
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      nv_sr1_ff <= SR1_RST;
      v_sr1_ff <= SR1_RST;
      vact_ff <= 1'b0;
    end
    else
    begin
      nv_sr1_ff <= nxt_nv_sr1;
      v_sr1_ff <= nxt_v_sr1;
      vact_ff <= nxt_vact;
    end
  end
  // Addressing state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      addr4_ff <= 1'b0;
      ext_ff <= EXT_RST;
    end
    else
    begin
      addr4_ff <= nxt_addr4;
      ext_ff <= nxt_ext;
    end
  end
  // Read modes, plus a registered copy of quad enable
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cont_ff <= 1'b0;
      qpi_ff <= 1'b0;
      qe_out_ff <= 1'b0;
    end
    else
    begin
      cont_ff <= nxt_cont;
      qpi_ff <= nxt_qpi;
      qe_out_ff <= nxt_vact ? nxt_v_sr1[QE_POS] : nxt_nv_sr1[QE_POS];
    end
  end
  // All outputs straight from flops
  assign lnk.ack = ack_ff;
  assign lnk.rdata = rdata_ff;
  assign addr4_mode = addr4_ff;
  assign cont_mode = cont_ff;
  assign quad_mode = qpi_ff;
  assign quad_enable = qe_out_ff;
  assign ext_addr = ext_ff;
endmodule

/* File: fptr_pkg.sv */
// Shared constants for the flash parameter table readout pair.
// Assumes both ends run on one clock (pclk) and one reset (presetn).
package fptr_pkg;
  // Link opcodes, one byte each
  localparam logic [7:0] OP_RD_TABLE = 8'h5a; // Parameter table byte read
  localparam logic [7:0] OP_WREN = 8'h06; // Non-volatile write enable
  localparam logic [7:0] OP_VWREN = 8'h50; // Volatile status write enable
  localparam logic [7:0] OP_WRSR1 = 8'h01; // Write status register 1
  localparam logic [7:0] OP_RDSR1 = 8'h05; // Read status register 1
  localparam logic [7:0] OP_RST_EN = 8'h66; // Reset enable
  localparam logic [7:0] OP_RST = 8'h99; // Reset
  localparam logic [7:0] OP_EN4B = 8'hb7; // Enter 4-byte addressing
  localparam logic [7:0] OP_EX4B = 8'he9; // Exit 4-byte addressing
  localparam logic [7:0] OP_WR_EXT = 8'hc5; // Write extended address
  localparam logic [7:0] OP_RD_EXT = 8'hc8; // Read extended address
  localparam logic [7:0] OP_QREAD = 8'heb; // Quad read, arg is mode byte
  localparam logic [7:0] OP_MODE_RST = 8'hff; // All ones on data lines
  localparam logic [7:0] OP_QPI_QE = 8'h38; // Quad entry needing enable
  localparam logic [7:0] OP_QPI_DIR = 8'h35; // Quad entry, no enable
  localparam logic [7:0] OP_RD_STATE = 8'h3f; // Read device mode flags
  // Mode byte values
  localparam logic [7:0] MODE_ENTER = 8'ha5;
  localparam logic [3:0] MODE_NIB = 4'ha;
  localparam logic [7:0] MODE_EXIT = 8'h00;
  // Clocks of all ones needed to leave continuous mode
  localparam logic [7:0] EXIT_CLK_3B = 8'h08;
  localparam logic [7:0] EXIT_CLK_4B = 8'h0a;
  // Quad enable position in status register 1, reset values
  localparam int QE_POS = 6;
  localparam logic [7:0] SR1_RST = 8'h00;
  localparam logic [7:0] EXT_RST = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  // Parameter table byte addresses and contents
  localparam logic [7:0] PT_A68 = 8'h68;
  localparam logic [7:0] PT_A69 = 8'h69;
  localparam logic [7:0] PT_A6A = 8'h6a;
  localparam logic [7:0] PT_A6B = 8'h6b;
  localparam logic [7:0] PT_A6C = 8'h6c;
  localparam logic [7:0] PT_A6D = 8'h6d;
  localparam logic [7:0] PT_A6E = 8'h6e;
  localparam logic [7:0] PT_A6F = 8'h6f;
  localparam logic [7:0] PT_AC0 = 8'hc0;
  localparam logic [7:0] PT_AC1 = 8'hc1;
  localparam logic [7:0] PT_AC2 = 8'hc2;
  localparam logic [7:0] PT_AC3 = 8'hc3;
  localparam logic [7:0] PT_D68 = 8'h19; // 4-4-4 exit 1001b, enable 0001b
  localparam logic [7:0] PT_D69 = 8'hf5; // Exit 111101b, bit 8 set
  localparam logic [7:0] PT_D6A = 8'h4d; // Bit 23 0, field 100b, entry 1101b
  localparam logic [7:0] PT_D6B = 8'hff;
  localparam logic [7:0] PT_D6C = 8'he9; // Bit 7 1, field 1101001b
  localparam logic [7:0] PT_D6D = 8'h10; // Soft reset 010000b, exit 00b
  localparam logic [7:0] PT_D6E = 8'hc0;
  localparam logic [7:0] PT_D6F = 8'h80;
  localparam logic [7:0] PT_DC0 = 8'h00;
  localparam logic [7:0] PT_DC1 = 8'h00;
  localparam logic [7:0] PT_DC2 = 8'hf0;
  localparam logic [7:0] PT_DC3 = 8'hff;
  localparam logic [7:0] PT_DFILL = 8'hff; // Bytes outside this table
  // Host APB map and fields
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_ARG_LSB = 8;
  localparam int CTRL_SEQ_RST = 16;
  localparam int CTRL_SEQ_EXIT = 17;
  localparam int STAT_BUSY = 0;
  localparam int STAT_ADDR4 = 1;
  localparam int STAT_DATA_LSB = 8;
  localparam logic [31:0] APB_ZERO = 32'h0000_0000;
endpackage

/* File: fptr_link_if.sv */
// Link between the flash parameter host and the flash device.
// Assumes both ends share pclk; the bench joins the two modports.
`timescale 1ns/1ps
interface fptr_link_if;
  logic req; // One-cycle command pulse
  logic [7:0] op; // Opcode
  logic [7:0] arg; // Address, mode byte or data
  logic ack; // One-cycle answer pulse
  logic [7:0] rdata; // Answer byte, valid with ack
  modport dev (input req, input op, input arg, output ack, output rdata);
  modport host (output req, output op, output arg, input ack, input rdata);
endinterface

/* File: fptr_table_rom.sv */
// Constant lookup of the parameter table bytes.
// Assumes a byte address from logic on the same clock.
`timescale 1ns/1ps
module fptr_table_rom
  import fptr_pkg::*;
(
  input wire logic [7:0] addr,
  output logic [7:0] data
);
  // Fixed contents; nothing can write them
  assign data = (addr == PT_A68) ? PT_D68 :
                (addr == PT_A69) ? PT_D69 :
                (addr == PT_A6A) ? PT_D6A :
                (addr == PT_A6B) ? PT_D6B :
                (addr == PT_A6C) ? PT_D6C :
                (addr == PT_A6D) ? PT_D6D :
                (addr == PT_A6E) ? PT_D6E :
                (addr == PT_A6F) ? PT_D6F :
                (addr == PT_AC0) ? PT_DC0 :
                (addr == PT_AC1) ? PT_DC1 :
                (addr == PT_AC2) ? PT_DC2 :
                (addr == PT_AC3) ? PT_DC3 : PT_DFILL;
endmodule

/* File: fptr_flash_host.sv */
// Host controller end: APB registers in, link commands out.
// Assumes an APB master on pclk; the link device answers with ack.
`timescale 1ns/1ps
module fptr_flash_host
  import fptr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  fptr_link_if.host lnk
);
  typedef enum logic [1:0] {FH_IDLE, FH_WAIT, FH_CHAIN} fptr_hst_t;
  fptr_hst_t st_ff;
  fptr_hst_t nxt_st;
  logic req_ff; // Link request pulse
  logic [7:0] op_ff; // Link opcode
  logic [7:0] arg_ff; // Link argument
  logic [7:0] rbyte_ff; // Last answer byte
  logic addr4_ff; // Tracked device address width
  logic armed_ff; // Last link command sent was reset enable
  logic [31:0] prdata_ff;
  logic pslverr_ff;
  // APB decode; zero wait states
  wire setup = psel && !penable;
  wire access = psel && penable;
  wire hit_ctrl = (paddr == REG_CTRL);
  wire hit_stat = (paddr == REG_STAT);
  wire busy = (st_ff != FH_IDLE);
  // A control write while busy is dropped
  wire start = access && pwrite && hit_ctrl && !busy;
  wire seq_rst = pwdata[CTRL_SEQ_RST];
  wire seq_exit = pwdata[CTRL_SEQ_EXIT];
  // Exit needs 10 clocks in 4-byte mode, 8 otherwise
  wire [7:0] exit_cnt = addr4_ff ? EXIT_CLK_4B : EXIT_CLK_3B;
  // Soft reset always opens with the enable command
  wire [7:0] cmd_op = seq_rst ? OP_RST_EN :
                      seq_exit ? OP_MODE_RST :
                      pwdata[CTRL_OP_LSB +: 8];
  wire [7:0] cmd_arg = seq_exit ? exit_cnt : pwdata[CTRL_ARG_LSB +: 8];
  wire chain_done = (st_ff == FH_CHAIN) && lnk.ack;
  // A bare 99h leaves the device in 4-byte mode, so only an armed one counts
  wire rst_hit = req_ff && (op_ff == OP_RST) && armed_ff;
  wire ex4b_hit = req_ff && (op_ff == OP_EX4B);
  // Status word
  wire [31:0] stat_word = {16'h0000, rbyte_ff, 6'b000000, addr4_ff, busy};
  wire [31:0] rd_mux = hit_stat ? stat_word : APB_ZERO;
  // Sequencer: chain holds until the 66h answer, then sends 99h
  assign nxt_st = start ? (seq_rst ? FH_CHAIN : FH_WAIT) :
                  chain_done ? FH_WAIT :
                  (lnk.ack && st_ff == FH_WAIT) ? FH_IDLE : st_ff;
  // Sequencer state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_ff <= FH_IDLE;
    else
      st_ff <= nxt_st;
  end
  // Link request; the second reset command follows the first answer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      req_ff <= 1'b0;
      op_ff <= BYTE_ZERO;
      arg_ff <= BYTE_ZERO;
    end
    else
    begin
      req_ff <= start || chain_done;
      // Quad read passes the mode byte as given; software sets enable first
      if (start)
      begin
        op_ff <= cmd_op;
        arg_ff <= cmd_arg;
      end
      else if (chain_done)
        op_ff <= OP_RST;
    end
  end
  // Answer capture and tracking of the address width
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rbyte_ff <= BYTE_ZERO;
      addr4_ff <= 1'b0;
      armed_ff <= 1'b0;
    end
    else
    begin
      if (lnk.ack)
        rbyte_ff <= lnk.rdata;
      // Mirrors the device: any other command disarms the reset
      if (req_ff)
        armed_ff <= (op_ff == OP_RST_EN);
      if (req_ff && op_ff == OP_EN4B)
        addr4_ff <= 1'b1;
      else if (ex4b_hit || rst_hit)
        addr4_ff <= 1'b0;
    end
  end
  // Read data and error prepared in the setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_ff <= APB_ZERO;
      pslverr_ff <= 1'b0;
    end
    else if (setup)
    begin
      prdata_ff <= rd_mux;
      pslverr_ff <= !(hit_ctrl || hit_stat);
    end
  end
  assign prdata = prdata_ff;
  assign pready = 1'b1;
  assign pslverr = pslverr_ff;
  assign lnk.req = req_ff;
  assign lnk.op = op_ff;
  assign lnk.arg = arg_ff;
endmodule

/* File: fptr_assertions.sv */
// Link checker for the flash parameter table pair: handshake and table fields.
// Assumes one clock and the link signals of the interface joining both ends.
`timescale 1ns/1ps
module fptr_assertions
  import fptr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic req,
  input wire logic [7:0] op,
  input wire logic [7:0] arg,
  input wire logic ack,
  input wire logic [7:0] rdata
);
  // All checks on the one clock, quiet while reset is low
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Table byte read of one address; answer lands one cycle later
  sequence s_rd(logic [7:0] a);
    req && op == OP_RD_TABLE && arg == a;
  endsequence
  // Answer pulse lasts exactly one cycle
  sequence s_ans;
    ack ##1 !ack;
  endsequence

  property p_ack_next;
    req |=> s_ans;
  endproperty
  property p_ack_cause;
    ack |-> $past(req);
  endproperty
  property p_cont_ok;
    s_rd(8'h69) |=> ack && rdata[0];
  endproperty
  property p_exit_field;
    s_rd(8'h69) |=> rdata[7:2] == 6'b111101;
  endproperty
  property p_entry_field;
    s_rd(8'h6a) |=> rdata[3:0] == 4'b1101;
  endproperty
  property p_qe_field;
    s_rd(8'h6a) |=> rdata[6:4] == 3'b100;
  endproperty
  property p_hold_bit;
    s_rd(8'h6a) |=> !rdata[7];
  endproperty
  property p_sr1_we;
    s_rd(8'h6c) |=> rdata[6:0] == 7'b1101001;
  endproperty
  property p_srst_field;
    s_rd(8'h6d) |=> rdata[5:0] == 6'b010000;
  endproperty
  property p_en4b_field;
    s_rd(8'h6f) |=> rdata == 8'h80;
  endproperty
  property p_c0_zero;
    s_rd(8'hc0) |=> rdata == 8'h00;
  endproperty

  a_ack_next: assert property (p_ack_next) else $error("ack pulse missing");
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  a_cont_ok: assert property (p_cont_ok) else $error("byte 69h bit 0 clear");
  a_exit_field: assert property (p_exit_field) else $error("exit field bad");
  a_entry_field: assert property (p_entry_field) else $error("entry field bad");
  a_qe_field: assert property (p_qe_field) else $error("enable field bad");
  a_hold_bit: assert property (p_hold_bit) else $error("hold bit set");
  a_sr1_we: assert property (p_sr1_we) else $error("sr1 field bad");
  a_srst_field: assert property (p_srst_field) else $error("reset field bad");
  a_en4b_field: assert property (p_en4b_field) else $error("enter field bad");
  a_c0_zero: assert property (p_c0_zero) else $error("byte C0h not zero");
endmodule

/* File: testbench.sv */
// Testbench: APB orders into the host, device state pins watched.
// Assumes host and device meet on one link interface and one clock.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_errors++; \
  $display("unexpected %s expected %h seen %h", nm, e, g); end end
module testbench
  import fptr_pkg::*;
;
  logic pclk = 1'b0; // 100 MHz
  logic presetn = 1'b0; // Held low three cycles
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic addr4_mode;
  logic cont_mode;
  logic quad_mode;
  logic quad_enable;
  logic [7:0] ext_addr;
  logic [31:0] rw; // Last APB read word
  logic err; // Last APB error flag
  logic [7:0] rb; // Last link answer byte
  int n_errors = 0;
  int checked = 0;
  // Table addresses and field values they must report
  logic [7:0] ta [6] = '{8'h69, 8'h6a, 8'h6c, 8'h6d, 8'h6f, 8'hc0};
  logic [7:0] td [6] = '{8'hf5, 8'h4d, 8'he9, 8'h10, 8'h80, 8'h00};

  fptr_link_if lnk();
  fptr_flash_host u_fptr_flash_host (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .lnk(lnk));
  fptr_flash_dev u_fptr_flash_dev (.pclk(pclk), .presetn(presetn), .lnk(lnk),
    .addr4_mode(addr4_mode), .cont_mode(cont_mode), .quad_mode(quad_mode),
    .quad_enable(quad_enable), .ext_addr(ext_addr));
  fptr_assertions u_fptr_assertions (.pclk(pclk), .presetn(presetn), .req(lnk.req),
    .op(lnk.op), .arg(lnk.arg), .ack(lnk.ack), .rdata(lnk.rdata));

  // Free-running clock
  always #5 pclk = ~pclk;

  // One APB transfer; an idle cycle after keeps strobes single-driven
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rw = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // Order one link command, then poll busy with a bound
  task automatic cmd(input logic [7:0] o, input logic [7:0] g, input logic [1:0] s);
    int n;
    apb(1'b1, REG_CTRL, {14'h0000, s, g, o});
    n = 0;
    do
    begin
      apb(1'b0, REG_STAT, APB_ZERO);
      n++;
    end
    while (rw[STAT_BUSY] !== 1'b0 && n < 20);
    `CHK("busy", 1'b0, rw[STAT_BUSY])
    rb = rw[15:8];
  endtask

  // Verdict and end of run
  task automatic test_done;
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Watchdog, far beyond the few hundred cycles the tests need
  initial
  begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    test_done();
  end

  // Main sequence
  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    `CHK("modes", 4'h0, {addr4_mode, cont_mode, quad_mode, quad_enable})
    apb(1'b0, REG_CTRL, APB_ZERO);
    `CHK("ctrl", APB_ZERO, rw)
    `CHK("okerr", 1'b0, err)
    apb(1'b0, 8'h20, APB_ZERO); // Unmapped: error, zero data
    `CHK("slverr", 1'b1, err)
    `CHK("unmapped", APB_ZERO, rw)
    apb(1'b1, REG_STAT, 32'hffff_ffff); // Ignored write
    apb(1'b0, REG_STAT, APB_ZERO);
    `CHK("stat", APB_ZERO, rw)
    foreach (ta[i])
    begin
      cmd(OP_RD_TABLE, ta[i], 2'b00);
      `CHK("table", td[i], rb)
    end
    // Quad entries refused while enable is clear
    cmd(OP_QREAD, MODE_ENTER, 2'b00);
    `CHK("cont", 1'b0, cont_mode)
    cmd(OP_QPI_QE, 8'h00, 2'b00);
    `CHK("quad", 1'b0, quad_mode)
    cmd(OP_WREN, 8'h00, 2'b00);
    cmd(OP_WRSR1, 8'h40, 2'b00);
    `CHK("qe", 1'b1, quad_enable)
    cmd(OP_QREAD, MODE_ENTER, 2'b00);
    `CHK("cont", 1'b1, cont_mode)
    cmd(OP_QREAD, MODE_EXIT, 2'b00);
    `CHK("cont", 1'b0, cont_mode)
    cmd(OP_QREAD, 8'ha3, 2'b00);
    `CHK("cont", 1'b1, cont_mode)
    cmd(8'h00, 8'h00, 2'b10); // Exit sequence, 3-byte mode
    `CHK("cont", 1'b0, cont_mode)
    cmd(OP_QPI_QE, 8'h00, 2'b00);
    `CHK("quad", 1'b1, quad_mode)
    // Four-byte addressing and the extended address register
    cmd(OP_EN4B, 8'h00, 2'b00);
    `CHK("addr4", 2'b11, {addr4_mode, rw[STAT_ADDR4]})
    cmd(OP_RST, 8'h00, 2'b00); // Reset without its enable
    `CHK("addr4", 2'b11, {addr4_mode, rw[STAT_ADDR4]})
    cmd(OP_WR_EXT, 8'h12, 2'b00);
    `CHK("ext", 8'h12, ext_addr)
    cmd(OP_RD_EXT, 8'h00, 2'b00);
    `CHK("ext rd", 8'h12, rb)
    cmd(OP_QREAD, MODE_ENTER, 2'b00);
    cmd(OP_MODE_RST, 8'h08, 2'b00); // Too few clocks in 4-byte mode
    `CHK("cont", 1'b1, cont_mode)
    cmd(8'h00, 8'h00, 2'b10);
    `CHK("cont", 1'b0, cont_mode)
    // Soft reset sequence: modes off, non-volatile enable kept
    cmd(8'h00, 8'h00, 2'b01);
    `CHK("reset", 12'h001, {addr4_mode, cont_mode, quad_mode, ext_addr, quad_enable})
    cmd(OP_QPI_DIR, 8'h00, 2'b00);
    `CHK("quad", 1'b1, quad_mode)
    cmd(OP_EN4B, 8'h00, 2'b00);
    cmd(OP_EX4B, 8'h00, 2'b00);
    `CHK("addr4", 1'b0, addr4_mode)
    // Volatile copy overrides, soft reset drops it
    cmd(OP_VWREN, 8'h00, 2'b00);
    cmd(OP_WRSR1, 8'h00, 2'b00);
    `CHK("qe", 1'b0, quad_enable)
    cmd(OP_RDSR1, 8'h00, 2'b00);
    `CHK("sr1", 8'h00, rb)
    cmd(8'h00, 8'h00, 2'b01);
    `CHK("qe", 1'b1, quad_enable)
    cmd(OP_RD_TABLE, 8'h6a, 2'b00); // Table unchanged by all of the above
    `CHK("table", 8'h4d, rb)
    cmd(OP_RD_STATE, 8'h00, 2'b00); // Only quad enable left after reset
    `CHK("state", 8'h01, rb)
    test_done();
  end
endmodule
